// >>> ptm_framer.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_framer
  import ptm_framer_pkg::*;
#(
  parameter int GAP_W = 8
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic [GAP_W-1:0] TX_OCTET_GAP_I,
  // packet side, transmit direction
  input wire logic TX_PKT_CLK_I,
  input wire logic [7:0] TX_PACKET_OCTET_I,
  input wire logic TX_AVBL_I,
  input wire logic TX_ERR_I,
  input wire logic TX_FIRST_OCTET_MARK_I,
  input wire logic TX_LAST_OCTET_MARK_I,
  output logic TX_ENBL_O,
  // packet side, receive direction
  input wire logic RX_PKT_CLK_I,
  output logic [7:0] RX_PACKET_OCTET_O,
  output logic RX_ENBL_O,
  output logic [1:0] RX_ERR_O,
  output logic RX_FIRST_OCTET_MARK_O,
  output logic RX_LAST_OCTET_MARK_O,
  // framed side toward the channel framing
  output logic [7:0] TX_LINE_OCTET_O,
  output logic TX_LINE_VALID_O,
  input wire logic TX_LINE_READY_I,
  input wire logic [7:0] RX_LINE_OCTET_I,
  input wire logic RX_LINE_VALID_I,
  output logic RX_LINE_READY_O
);

  initial begin
    if (GAP_W < 1 || GAP_W > 16) $error("ptm_framer: GAP_W out of range");
  end

  // reset release per clock domain, assert stays asynchronous
  logic [1:0] mrst_r, trst_r, rrst_r;
  logic mrst_n, trst_n, rrst_n;
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) mrst_r <= RESET_SYNC_INIT;
    else mrst_r <= {mrst_r[0], 1'b1};
  end
  always_ff @(posedge TX_PKT_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) trst_r <= RESET_SYNC_INIT;
    else trst_r <= {trst_r[0], 1'b1};
  end
  always_ff @(posedge RX_PKT_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) rrst_r <= RESET_SYNC_INIT;
    else rrst_r <= {rrst_r[0], 1'b1};
  end
  assign mrst_n = mrst_r[1];
  assign trst_n = trst_r[1];
  assign rrst_n = rrst_r[1];

  // ---------------- transmit packet side, entity clock
  tx_word_s tx_in_word, tx_word;
  logic tx_src_ready, tx_take, tx_enbl_r, tx_enbl_nxt;
  logic tx_word_vld, tx_word_rdy;

  // a word is taken only on an enabled edge; enable drops until handed over
  assign tx_take = tx_enbl_r && (TX_AVBL_I || TX_ERR_I);
  assign tx_in_word = '{abort: TX_ERR_I,
                        first: TX_FIRST_OCTET_MARK_I,
                        last: TX_LAST_OCTET_MARK_I,
                        octet: TX_PACKET_OCTET_I};
  assign tx_enbl_nxt = tx_src_ready && !tx_take;

  always_ff @(posedge TX_PKT_CLK_I or negedge trst_n) begin
    if (!trst_n) tx_enbl_r <= 1'b0;
    else tx_enbl_r <= tx_enbl_nxt;
  end
  assign TX_ENBL_O = tx_enbl_r;

  // transmit words cross into the system clock by toggle handshake
  word_cdc #(.W($bits(tx_word_s))) u_tx_cdc (
    .src_clk_i(TX_PKT_CLK_I),
    .src_rst_n_i(trst_n),
    .src_valid_i(tx_take),
    .src_ready_o(tx_src_ready),
    .src_data_i(tx_in_word),
    .dst_clk_i(MCLK_I),
    .dst_rst_n_i(mrst_n),
    .dst_ce_i(CE_I),
    .dst_valid_o(tx_word_vld),
    .dst_ready_i(tx_word_rdy),
    .dst_data_o(tx_word)
  );

  // ---------------- transmit framer, system clock
  tx_state_e tx_st_r, tx_st_nxt;
  logic [15:0] tcrc_r, tcrc_nxt;
  logic esc_pend_r, esc_pend_nxt;
  logic [7:0] esc_oct_r, esc_oct_nxt;
  logic [7:0] line_oct_r, line_oct_nxt;
  logic line_vld_r, line_vld_nxt;
  logic [GAP_W-1:0] gap_r, gap_nxt;
  logic t_emit, t_is_data, t_can;
  logic [7:0] t_raw, t_out;

  always_comb begin
    tx_st_nxt = tx_st_r;
    tcrc_nxt = tcrc_r;
    esc_pend_nxt = esc_pend_r;
    esc_oct_nxt = esc_oct_r;
    line_oct_nxt = line_oct_r;
    line_vld_nxt = line_vld_r;
    gap_nxt = gap_r;
    tx_word_rdy = 1'b0;
    t_emit = 1'b0;
    t_is_data = 1'b0;
    t_raw = FLAG_OCT;
    t_out = FLAG_OCT;
    if (line_vld_r && TX_LINE_READY_I) line_vld_nxt = 1'b0;
    // pacing gap sets the framed octet rate below the line maximum
    t_can = (!line_vld_r || TX_LINE_READY_I) && (gap_r == '0);
    if (gap_r != '0) gap_nxt = gap_r - 1'b1;
    if (t_can) begin
      if (esc_pend_r) begin
        t_emit = 1'b1;
        t_raw = esc_oct_r;
        esc_pend_nxt = 1'b0;
      end else begin
        case (tx_st_r)
          TX_IDLE: begin
            // idle flags double as closing and opening flag
            t_emit = 1'b1;
            tcrc_nxt = CRC_INIT;
            if (tx_word_vld) begin
              if (tx_word.first && !tx_word.abort) tx_st_nxt = TX_ADDR;
              else tx_word_rdy = 1'b1; // stray or aborted remainder dropped
            end
          end
          TX_ADDR: begin
            t_emit = 1'b1;
            t_is_data = 1'b1;
            t_raw = ADDR_OCT;
            tx_st_nxt = TX_CTRL;
          end
          TX_CTRL: begin
            t_emit = 1'b1;
            t_is_data = 1'b1;
            t_raw = CTRL_OCT;
            tx_st_nxt = TX_DATA;
          end
          TX_DATA: begin
            // underrun leaves the line without an octet this cycle
            if (tx_word_vld) begin
              tx_word_rdy = 1'b1;
              t_emit = 1'b1;
              if (tx_word.abort) begin
                t_raw = ESC_OCT;
                tx_st_nxt = TX_ABORT;
              end else begin
                t_is_data = 1'b1;
                t_raw = tx_word.octet;
                if (tx_word.last) tx_st_nxt = TX_FCS1;
              end
            end
          end
          TX_FCS1: begin
            t_emit = 1'b1;
            t_is_data = 1'b1;
            t_raw = ~tcrc_r[7:0];
            tx_st_nxt = TX_FCS2;
          end
          TX_FCS2: begin
            t_emit = 1'b1;
            t_is_data = 1'b1;
            t_raw = ~tcrc_r[15:8];
            tx_st_nxt = TX_IDLE;
          end
          TX_ABORT: begin
            t_emit = 1'b1; // flag right after escape marks the abort
            tx_st_nxt = TX_IDLE;
          end
          default: tx_st_nxt = TX_IDLE;
        endcase
        // crc covers address, control and information only
        if (t_is_data && (tx_st_r != TX_FCS1) && (tx_st_r != TX_FCS2)) begin
          tcrc_nxt = crc_step(tcrc_r, t_raw);
        end
      end
      t_out = t_raw;
      if (t_is_data && (t_raw == FLAG_OCT || t_raw == ESC_OCT)) begin
        t_out = ESC_OCT;
        esc_pend_nxt = 1'b1;
        esc_oct_nxt = t_raw ^ STUFF_XOR;
      end
      if (t_emit) begin
        line_oct_nxt = bit_rev(t_out);
        line_vld_nxt = 1'b1;
        gap_nxt = TX_OCTET_GAP_I;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge mrst_n) begin
    if (!mrst_n) begin
      tx_st_r <= TX_IDLE;
      tcrc_r <= CRC_INIT;
      esc_pend_r <= 1'b0;
      esc_oct_r <= 8'h00;
      line_oct_r <= 8'h00;
      line_vld_r <= 1'b0;
      gap_r <= '0;
    end else if (CE_I) begin
      tx_st_r <= tx_st_nxt;
      tcrc_r <= tcrc_nxt;
      esc_pend_r <= esc_pend_nxt;
      esc_oct_r <= esc_oct_nxt;
      line_oct_r <= line_oct_nxt;
      line_vld_r <= line_vld_nxt;
      gap_r <= gap_nxt;
    end
  end
  assign TX_LINE_OCTET_O = line_oct_r;
  assign TX_LINE_VALID_O = line_vld_r;

  // ---------------- receive deframer, system clock
  rx_state_e rx_st_r, rx_st_nxt;
  logic [15:0] rcrc_r, rcrc_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] d0_r, d0_nxt, d1_r, d1_nxt, hold_r, hold_nxt;
  logic hold_vld_r, hold_vld_nxt, hold_first_r, hold_first_nxt;
  rx_word_s out_r, out_nxt;
  logic out_vld_r, out_vld_nxt, rrdy_r, rrdy_nxt, out_src_ready;
  logic r_acc, r_data, r_close, r_bad;
  logic [1:0] r_stat;
  logic [7:0] r_x, r_y;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rcrc_nxt = rcrc_r;
    cnt_nxt = cnt_r;
    d0_nxt = d0_r;
    d1_nxt = d1_r;
    hold_nxt = hold_r;
    hold_vld_nxt = hold_vld_r;
    hold_first_nxt = hold_first_r;
    out_nxt = out_r;
    out_vld_nxt = out_vld_r;
    r_data = 1'b0;
    r_close = 1'b0;
    r_bad = 1'b0;
    r_stat = RX_STAT_INVALID;
    r_y = 8'h00;
    if (out_vld_r && out_src_ready) out_vld_nxt = 1'b0;
    r_acc = RX_LINE_VALID_I && rrdy_r;
    r_x = bit_rev(RX_LINE_OCTET_I);
    if (r_acc) begin
      case (rx_st_r)
        RX_HUNT: begin
          if (r_x == FLAG_OCT) r_close = 1'b1;
        end
        RX_FRAME: begin
          if (r_x == FLAG_OCT) begin
            r_close = 1'b1;
            r_stat = (rcrc_r == CRC_GOOD_RESID) ? RX_STAT_GOOD
                                                : RX_STAT_FCS;
          end else if (r_x == ESC_OCT) begin
            rx_st_nxt = RX_ESC;
          end else begin
            r_data = 1'b1;
            r_y = r_x;
          end
        end
        RX_ESC: begin
          if (r_x == FLAG_OCT) begin
            r_close = 1'b1; // abort, flag opens the next
            r_bad = 1'b1;
          end else if (r_x == (FLAG_OCT ^ STUFF_XOR) ||
                       r_x == (ESC_OCT ^ STUFF_XOR)) begin
            r_data = 1'b1;
            r_y = r_x ^ STUFF_XOR;
            rx_st_nxt = RX_FRAME;
          end else begin
            r_bad = 1'b1; // unknown escape, then hunt
            rx_st_nxt = RX_HUNT;
          end
        end
        default: rx_st_nxt = RX_HUNT;
      endcase
    end
    // short frames never released an octet, so they vanish silently
    if ((r_close && !r_bad && cnt_r >= MIN_FRAME_OCTETS && hold_vld_r) ||
        (r_bad && hold_vld_r)) begin
      out_nxt = '{status: r_bad ? RX_STAT_INVALID : r_stat,
                  first: hold_first_r, last: 1'b1, octet: hold_r};
      out_vld_nxt = 1'b1;
    end
    if (r_close || r_bad) begin
      cnt_nxt = 3'h0;
      rcrc_nxt = CRC_INIT;
      hold_vld_nxt = 1'b0;
      if (r_close) rx_st_nxt = RX_FRAME;
    end
    // last two octets stay back as the check field
    if (r_data) begin
      rcrc_nxt = crc_step(rcrc_r, r_y);
      if (cnt_r != 3'h7) cnt_nxt = cnt_r + 3'h1;
      d0_nxt = r_y;
      d1_nxt = d0_r;
      if (cnt_r >= FIRST_INFO_CNT) begin
        if (hold_vld_r) begin
          out_nxt = '{status: RX_STAT_GOOD, first: hold_first_r,
                      last: 1'b0, octet: hold_r};
          out_vld_nxt = 1'b1;
        end
        hold_nxt = d1_r;
        hold_first_nxt = (cnt_r == FIRST_INFO_CNT);
        hold_vld_nxt = 1'b1;
      end
    end
    // line stalls while the single hand-over slot is occupied
    rrdy_nxt = !out_vld_nxt;
  end

  always_ff @(posedge MCLK_I or negedge mrst_n) begin
    if (!mrst_n) begin
      rx_st_r <= RX_HUNT;
      rcrc_r <= CRC_INIT;
      cnt_r <= 3'h0;
      d0_r <= 8'h00;
      d1_r <= 8'h00;
      hold_r <= 8'h00;
      hold_vld_r <= 1'b0;
      hold_first_r <= 1'b0;
      out_r <= '0;
      out_vld_r <= 1'b0;
      rrdy_r <= 1'b0;
    end else if (CE_I) begin
      rx_st_r <= rx_st_nxt;
      rcrc_r <= rcrc_nxt;
      cnt_r <= cnt_nxt;
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
      hold_r <= hold_nxt;
      hold_vld_r <= hold_vld_nxt;
      hold_first_r <= hold_first_nxt;
      out_r <= out_nxt;
      out_vld_r <= out_vld_nxt;
      rrdy_r <= rrdy_nxt;
    end
  end
  assign RX_LINE_READY_O = rrdy_r;

  // ---------------- receive packet side, entity clock
  rx_word_s rx_word;
  logic rx_word_vld, rx_handoff;
  logic rx_enbl_r;
  rx_word_s rx_o_r;

  // the source port is gated by clock enable directly, as well as by the slot register
  assign rx_handoff = out_vld_r && CE_I;

  word_cdc #(.W($bits(rx_word_s))) u_rx_cdc (
    .src_clk_i(MCLK_I),
    .src_rst_n_i(mrst_n),
    .src_valid_i(rx_handoff),
    .src_ready_o(out_src_ready),
    .src_data_i(out_r),
    .dst_clk_i(RX_PKT_CLK_I),
    .dst_rst_n_i(rrst_n),
    .dst_ce_i(1'b1),
    .dst_valid_o(rx_word_vld),
    .dst_ready_i(1'b1),
    .dst_data_o(rx_word)
  );

  // each octet is offered for exactly one entity clock
  always_ff @(posedge RX_PKT_CLK_I or negedge rrst_n) begin
    if (!rrst_n) begin
      rx_enbl_r <= 1'b0;
      rx_o_r <= '0;
    end else begin
      rx_enbl_r <= rx_word_vld;
      if (rx_word_vld) rx_o_r <= rx_word;
    end
  end
  assign RX_ENBL_O = rx_enbl_r;
  assign RX_PACKET_OCTET_O = rx_o_r.octet;
  assign RX_ERR_O = rx_o_r.status;
  assign RX_FIRST_OCTET_MARK_O = rx_o_r.first;
  assign RX_LAST_OCTET_MARK_O = rx_o_r.last;

endmodule : ptm_framer
`default_nettype wire

// >>> ptm_framer_pkg.sv
// Functional notes
// - two independent opposite octet packet streams, any length
// - packet bit one is lsb, sent first
// - transmit push only while transmit enable high
// - transmit error aborts the packet in flight
// - first octet marker on each packet
// - last octet marker on each packet
// - entity takes receive octets only while enabled
// - receive status: good, check error, invalid
// - packets pass transparently with integrity kept
// - one instance per latency channel, identical
// - transmit rate configurable below its maximum
// - frames open and close with 7E flag
// - one flag may close and open
// - address FF, control 03 when unused
// - information octets sent in ascending order
// - framed bit eight sent first serially
// - packet bit one maps to framed bit eight
// - 16-bit crc, preset ones, complement sent
// - escape 7E/7D as 7D, xor 20; abort
// - drop frames under five octets, uncounted
// - idle gaps filled with flags, discarded
`default_nettype none
package ptm_framer_pkg;

  localparam logic [7:0] FLAG_OCT = 8'h7E;
  localparam logic [7:0] ESC_OCT = 8'h7D;
  localparam logic [7:0] STUFF_XOR = 8'h20;
  localparam logic [7:0] ADDR_OCT = 8'hFF;
  localparam logic [7:0] CTRL_OCT = 8'h03;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_GOOD_RESID = 16'hF0B8;
  localparam logic [2:0] MIN_FRAME_OCTETS = 3'h5;
  localparam logic [2:0] FIRST_INFO_CNT = 3'h4;
  localparam logic [1:0] RESET_SYNC_INIT = 2'h0;

  // receive status codes on the error output
  localparam logic [1:0] RX_STAT_GOOD = 2'h0;
  localparam logic [1:0] RX_STAT_FCS = 2'h1;
  localparam logic [1:0] RX_STAT_INVALID = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_ADDR = 3'b001,
    TX_CTRL = 3'b010,
    TX_DATA = 3'b011,
    TX_FCS1 = 3'b100,
    TX_FCS2 = 3'b101,
    TX_ABORT = 3'b110
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_FRAME = 2'b01,
    RX_ESC = 2'b10
  } rx_state_e;

  typedef struct packed {
    logic abort;
    logic first;
    logic last;
    logic [7:0] octet;
  } tx_word_s;

  typedef struct packed {
    logic [1:0] status;
    logic first;
    logic last;
    logic [7:0] octet;
  } rx_word_s;

  // reflected crc step, one octet, bit one first
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [7:0] oct);
    logic [15:0] c;
    c = crc ^ {8'h00, oct};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  // swap bit order between packet and framed numbering
  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : bit_rev

endpackage : ptm_framer_pkg
`default_nettype wire

// >>> word_cdc.sv
`timescale 1ns/1ps
`default_nettype none
module word_cdc #(
  parameter int W = 11
) (
  input wire logic src_clk_i,
  input wire logic src_rst_n_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic [W-1:0] src_data_i,
  input wire logic dst_clk_i,
  input wire logic dst_rst_n_i,
  input wire logic dst_ce_i,
  output logic dst_valid_o,
  input wire logic dst_ready_i,
  output logic [W-1:0] dst_data_o
);

  initial begin
    if (W < 1) $error("word_cdc: width must be at least one");
  end

  logic req_r, req_nxt, busy_r, busy_nxt;
  logic [W-1:0] hold_r, hold_nxt;
  logic [1:0] ack_sync_r;
  logic ack_seen_r;
  logic [1:0] req_sync_r;
  logic req_seen_r, req_seen_nxt, ack_r, ack_nxt;

  // source side: word held stable while the toggle travels across
  always_comb begin
    req_nxt = req_r;
    busy_nxt = busy_r;
    hold_nxt = hold_r;
    if (!busy_r && src_valid_i) begin
      req_nxt = ~req_r;
      busy_nxt = 1'b1;
      hold_nxt = src_data_i;
    end else if (busy_r && (ack_sync_r[1] != ack_seen_r)) begin
      busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      req_r <= 1'b0;
      busy_r <= 1'b0;
      hold_r <= '0;
      ack_sync_r <= 2'h0;
      ack_seen_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
      ack_sync_r <= {ack_sync_r[0], ack_r};
      ack_seen_r <= ack_sync_r[1];
    end
  end

  assign src_ready_o = !busy_r;

  // destination side: new toggle means the held word is valid
  always_comb begin
    req_seen_nxt = req_seen_r;
    ack_nxt = ack_r;
    if (dst_valid_o && dst_ready_i) begin
      req_seen_nxt = req_sync_r[1];
      ack_nxt = ~ack_r;
    end
  end

  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
    if (!dst_rst_n_i) begin
      req_sync_r <= 2'h0;
      req_seen_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (dst_ce_i) begin
      req_sync_r <= {req_sync_r[0], req_r};
      req_seen_r <= req_seen_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign dst_valid_o = req_sync_r[1] != req_seen_r;
  assign dst_data_o = hold_r;

endmodule : word_cdc
`default_nettype wire

// >>> ptm_framer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_framer_monitor (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic TX_PKT_CLK_I,
  input wire logic TX_AVBL_I,
  input wire logic TX_ERR_I,
  input wire logic TX_ENBL_O,
  input wire logic RX_PKT_CLK_I,
  input wire logic [7:0] RX_PACKET_OCTET_O,
  input wire logic RX_ENBL_O,
  input wire logic RX_FIRST_OCTET_MARK_O,
  input wire logic RX_LAST_OCTET_MARK_O,
  input wire logic [7:0] TX_LINE_OCTET_O,
  input wire logic TX_LINE_VALID_O,
  input wire logic TX_LINE_READY_I
);
  logic taken;
  logic [7:0] prev_r, prev_nxt, prev2_r, prev2_nxt;
  logic in_pkt_r, in_pkt_nxt;

  // last two octets taken by the lower side, pin bit order
  assign taken = TX_LINE_VALID_O && TX_LINE_READY_I;
  always_comb begin
    prev_nxt = taken ? TX_LINE_OCTET_O : prev_r;
    prev2_nxt = taken ? prev_r : prev2_r;
  end
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prev_r <= 8'h00;
      prev2_r <= 8'h00;
    end else begin
      prev_r <= prev_nxt;
      prev2_r <= prev2_nxt;
    end
  end

  // open packet tracker, so a lost last mark shows on the next first
  always_comb in_pkt_nxt = RX_ENBL_O ? !RX_LAST_OCTET_MARK_O : in_pkt_r;
  always_ff @(posedge RX_PKT_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) in_pkt_r <= 1'h0;
    else in_pkt_r <= in_pkt_nxt;
  end

  property p_enbl_drop;
    @(posedge TX_PKT_CLK_I) disable iff (!RST_B_I)
      TX_ENBL_O && (TX_AVBL_I || TX_ERR_I) |=> !TX_ENBL_O;
  endproperty
  a_enbl_drop: assert property (p_enbl_drop) else $error("enable held");
  property p_line_hold;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      TX_LINE_VALID_O && !TX_LINE_READY_I
      |=> TX_LINE_VALID_O && $stable(TX_LINE_OCTET_O);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("octet lost");
  property p_addr;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      taken && prev_r == 8'h7E && TX_LINE_OCTET_O != 8'h7E
      |-> TX_LINE_OCTET_O == 8'hFF;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_ctrl;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      taken && prev2_r == 8'h7E && prev_r == 8'hFF
      |-> TX_LINE_OCTET_O == 8'hC0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("bad control");
  property p_stuff;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      taken && prev_r == 8'hBE |-> TX_LINE_OCTET_O inside {8'h7A, 8'hBA, 8'h7E};
  endproperty
  a_stuff: assert property (p_stuff) else $error("bad escape");
  property p_rx_pulse;
    @(posedge RX_PKT_CLK_I) disable iff (!RST_B_I) RX_ENBL_O |=> !RX_ENBL_O;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("long pulse");
  property p_rx_hold;
    @(posedge RX_PKT_CLK_I) disable iff (!RST_B_I)
      !RX_ENBL_O |-> $stable(RX_PACKET_OCTET_O);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("octet moved");
  property p_rx_first;
    @(posedge RX_PKT_CLK_I) disable iff (!RST_B_I)
      RX_ENBL_O |-> RX_FIRST_OCTET_MARK_O == !in_pkt_r;
  endproperty
  a_rx_first: assert property (p_rx_first) else $error("bad marks");
endmodule : ptm_framer_monitor

bind ptm_framer ptm_framer_monitor u_mon (
  .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .TX_PKT_CLK_I(TX_PKT_CLK_I),
  .TX_AVBL_I(TX_AVBL_I), .TX_ERR_I(TX_ERR_I), .TX_ENBL_O(TX_ENBL_O),
  .RX_PKT_CLK_I(RX_PKT_CLK_I), .RX_PACKET_OCTET_O(RX_PACKET_OCTET_O),
  .RX_ENBL_O(RX_ENBL_O), .RX_FIRST_OCTET_MARK_O(RX_FIRST_OCTET_MARK_O),
  .RX_LAST_OCTET_MARK_O(RX_LAST_OCTET_MARK_O),
  .TX_LINE_OCTET_O(TX_LINE_OCTET_O), .TX_LINE_VALID_O(TX_LINE_VALID_O),
  .TX_LINE_READY_I(TX_LINE_READY_I));
`default_nettype wire

// >>> packet_entity_model.sv
`timescale 1ns/1ps
`default_nettype none
module packet_entity_model import ptm_framer_pkg::*; (
  input wire logic tx_clk_i,
  input wire logic tx_enbl_i,
  output var tx_word_s tx_w_o,
  output logic tx_avbl_o,
  input wire logic rx_clk_i,
  input wire logic rx_enbl_i,
  input wire rx_word_s rx_w_i
);
  rx_word_s rxq[$];
  int stuck = 0;

  initial tx_avbl_o = 1'h0;
  initial tx_w_o = '0;

  // one word per enabled edge; slow leaves gaps
  task automatic send(input logic [7:0] p[$], input int err_at,
                      input int slow);
    int n;
    foreach (p[i]) begin
      @(negedge tx_clk_i);
      if (slow > 0 && i > 0) begin
        tx_avbl_o = 1'h0;
        tx_w_o = {1'h0, ~tx_w_o[9:0]};
        repeat (slow) @(negedge tx_clk_i);
      end
      tx_avbl_o = 1'h1;
      tx_w_o = '{abort: i == err_at, first: i == 0,
                 last: i == p.size() - 1, octet: p[i]};
      n = 0;
      do @(posedge tx_clk_i); while (tx_enbl_i !== 1'h1 && n++ < 300);
      if (n > 300) stuck = 5001;
    end
    @(negedge tx_clk_i);
    tx_avbl_o = 1'h0;
    tx_w_o = {1'h0, ~tx_w_o[9:0]}; // error low, rest inverted
  endtask : send

  // cannot stall: every enabled edge is taken
  always @(posedge rx_clk_i)
    if (rx_enbl_i === 1'h1) rxq.push_back(rx_w_i);
endmodule : packet_entity_model
`default_nettype wire

// >>> tb_ptm_framer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end \
end
module tb_ptm_framer import ptm_framer_pkg::*;;
  typedef logic [7:0] q8_t[$];
  logic mclk = 1'h0, tclk = 1'h0, rclk = 1'h0, rst_n = 1'h0;
  logic rdy = 1'h0, lvalid = 1'h0, avbl, tx_en, rx_en, rx_first, rx_last;
  logic line_v, rx_rdy;
  logic [7:0] loct = 8'h00, o, rx_oct, line_oct;
  logic [1:0] rx_err;
  tx_word_s txw;
  int compares = 0, num_errors = 0, stall = 0;
  q8_t txq;

  // the entity sources both packet clocks, phase unrelated to mclk
  always #5 mclk = ~mclk;
  initial #2.3 forever #15 tclk = ~tclk;
  initial #7.9 forever #15 rclk = ~rclk;

  ptm_framer u_ptm_framer (
    .MCLK_I(mclk), .RST_B_I(rst_n), .CE_I(1'h1), .TX_OCTET_GAP_I(8'h02),
    .TX_PKT_CLK_I(tclk), .TX_PACKET_OCTET_I(txw.octet), .TX_AVBL_I(avbl),
    .TX_ERR_I(txw.abort), .TX_FIRST_OCTET_MARK_I(txw.first),
    .TX_LAST_OCTET_MARK_I(txw.last), .TX_ENBL_O(tx_en), .RX_PKT_CLK_I(rclk),
    .RX_PACKET_OCTET_O(rx_oct), .RX_ENBL_O(rx_en), .RX_ERR_O(rx_err),
    .RX_FIRST_OCTET_MARK_O(rx_first), .RX_LAST_OCTET_MARK_O(rx_last),
    .TX_LINE_OCTET_O(line_oct), .TX_LINE_VALID_O(line_v),
    .TX_LINE_READY_I(rdy), .RX_LINE_OCTET_I(loct), .RX_LINE_VALID_I(lvalid),
    .RX_LINE_READY_O(rx_rdy));
  packet_entity_model entity (
    .tx_clk_i(tclk), .tx_enbl_i(tx_en), .tx_w_o(txw), .tx_avbl_o(avbl),
    .rx_clk_i(rclk), .rx_enbl_i(rx_en),
    .rx_w_i({rx_err, rx_first, rx_last, rx_oct}));

  // lower side stalls one cycle in four
  always @(negedge mclk) begin
    stall <= stall + 1;
    rdy <= stall[1:0] != 2'h3;
  end

  // line octets in packet bit order, runs of idle flags folded to one
  always @(posedge mclk) begin
    o = rev(line_oct);
    if (line_v === 1'h1 && rdy && !(o == 8'h7E && txq.size() > 0
        && txq[$] == 8'h7E)) txq.push_back(o);
  end

  function automatic logic [7:0] rev(input logic [7:0] v);
    rev = {<<{v}};
  endfunction : rev

  // framed octets in packet order; bad spoils the check field
  function automatic q8_t frame(input q8_t p, input logic bad);
    q8_t b, f;
    logic [15:0] c;
    b = {8'hFF, 8'h03, p};
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    c = ~c ^ {15'h0, bad};
    b = {b, c[7:0], c[15:8]};
    f = {8'h7E};
    foreach (b[i])
      if (b[i] == 8'h7E || b[i] == 8'h7D) f = {f, 8'h7D, b[i] ^ 8'h20};
      else f = {f, b[i]};
    return {f, 8'h7E};
  endfunction : frame

  task automatic limit(input int n);
    if (n > 5000) begin
      num_errors++;
      $display("unexpected wait: expected done seen %0d cycles", n);
      conclude();
    end
  endtask : limit

  task automatic tx_expect(input q8_t e);
    int n = 0;
    while (txq.size() < e.size() && n++ <= 5000) @(posedge mclk);
    limit(n + entity.stuck);
    foreach (e[i]) `CHK("line octet", e[i], txq[i])
  endtask : tx_expect

  // hold each octet until the deframer takes it
  task automatic line_send(input q8_t f);
    int n;
    foreach (f[i]) begin
      @(negedge mclk);
      lvalid = 1'h1;
      loct = rev(f[i]);
      n = 0;
      do @(posedge mclk); while (rx_rdy !== 1'h1 && n++ <= 5000);
      limit(n);
    end
    @(negedge mclk);
    lvalid = 1'h0;
    loct = ~loct;
  endtask : line_send

  task automatic rx_wait(input int cnt);
    int n = 0;
    while (entity.rxq.size() < cnt && n++ <= 5000) @(posedge mclk);
    limit(n);
    repeat (300) @(posedge mclk);
  endtask : rx_wait

  // escaped payload, then a one-octet packet sharing a flag; slow gaps only precede octets after the first, so none appear
  task automatic sc_tx_frame();
    q8_t p, e, f;
    @(negedge mclk);
    txq.delete();
    p = {8'h7E, 8'h7D, 8'h5A, 8'h00};
    e = frame(p, 1'h0);
    entity.send(p, -1, 0);
    p = {8'h81};
    f = frame(p, 1'h0);
    entity.send(p, -1, 3);
    tx_expect({e, f[1:$]});
  endtask : sc_tx_frame

  // abort in mid-packet; the tail must vanish, the next packet must not
  task automatic sc_tx_abort();
    q8_t p, e;
    @(negedge mclk);
    txq.delete();
    p = {8'h11, 8'h22, 8'h00, 8'h33};
    entity.send(p, 2, 1);
    p = {8'h44};
    e = frame(p, 1'h0);
    entity.send(p, -1, 0);
    tx_expect({8'h7E, 8'hFF, 8'h03, 8'h11, 8'h22, 8'h7D, 8'h7E, e[1:$]});
  endtask : sc_tx_abort

  // short frame dropped, then good and errored frames on one shared flag
  task automatic sc_rx_frames();
    q8_t p, f, e, x;
    entity.rxq.delete();
    p = {8'h7E, 8'hFF, 8'h03, 8'h7E};
    line_send(p);
    p = {8'h5A, 8'h7E, 8'h7D};
    f = frame(p, 1'h0);
    p = {8'hC3, 8'h99};
    e = frame(p, 1'h1);
    line_send({f, e[1:$]});
    rx_wait(5);
    `CHK("rx count", 5, entity.rxq.size())
    x = {8'h5A, 8'h7E, 8'h7D, 8'hC3, 8'h99};
    foreach (x[i]) begin
      `CHK("rx octet", x[i], entity.rxq[i].octet)
      `CHK("rx first", i == 0 || i == 3, entity.rxq[i].first)
      `CHK("rx last", i == 2 || i == 4, entity.rxq[i].last)
    end
    `CHK("rx status", RX_STAT_GOOD, entity.rxq[2].status)
    `CHK("rx status", RX_STAT_FCS, entity.rxq[4].status)
  endtask : sc_rx_frames

  // escape then flag aborts; that flag opens the next frame
  task automatic sc_rx_abort();
    q8_t p, f;
    entity.rxq.delete();
    p = {8'hE1};
    f = frame(p, 1'h0);
    line_send({8'h7E, 8'hFF, 8'h03, 8'hA1, 8'hB2, 8'hC4, 8'h7D, f});
    rx_wait(2);
    `CHK("rx octet", 8'hA1, entity.rxq[0].octet)
    `CHK("rx first", 1'h1, entity.rxq[0].first)
    `CHK("rx last", 1'h1, entity.rxq[$-1].last)
    `CHK("rx status", RX_STAT_INVALID, entity.rxq[$-1].status)
    `CHK("rx octet", 8'hE1, entity.rxq[$].octet)
    `CHK("rx marks", 2'h3, {entity.rxq[$].first, entity.rxq[$].last})
    `CHK("rx status", RX_STAT_GOOD, entity.rxq[$].status)
  endtask : sc_rx_abort

  task automatic conclude();
    $display("compares %0d, num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // reset held four system clocks
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'h1;
    repeat (20) @(posedge mclk);
    sc_tx_frame();
    sc_tx_abort();
    sc_rx_frames();
    sc_rx_abort();
    conclude();
  end
endmodule : tb_ptm_framer
`default_nettype wire
